// *** design/ccs_pkg.sv ***
/*
 Constants, register layout and carrier types for the codec clock startup control.
 Assumes a 10 MHz system clock and a byte-wide control port decoded elsewhere.
*/
package ccs_pkg;
   // =====================================================================
   // Register map
   localparam logic [15:0] CCS_CLK_ADDR = 16'h4000;
   localparam logic [15:0] CCS_PLL_ADDR = 16'h4002;
   localparam int CCS_CLK_EN_BIT = 0;
   localparam int CCS_FREQ_LSB = 1;
   localparam int CCS_SRC_BIT = 3;
   localparam int CCS_PLL_EN_BIT = 0;
   localparam int CCS_PLL_LOCK_BIT = 1;
   localparam logic [3:0] CCS_CLK_RESET = 4'h0;
   localparam logic [47:0] CCS_PLL_RESET = 48'h000000000000;
   localparam logic [2:0] CCS_PLL_BYTES = 3'h6;
   localparam logic [1:0] CCS_DIV_PLL = 2'h3;

   // =====================================================================
   // Timing
   localparam int CCS_CLK_HZ = 10000000;
   localparam int CCS_LOCK_TIME_US = 3000;
   localparam int CCS_BOOT_TIME_US = 200;
   localparam int CCS_LOCK_CYCLES = CCS_LOCK_TIME_US * (CCS_CLK_HZ / 1000000);
   localparam int CCS_BOOT_CYCLES = CCS_BOOT_TIME_US * (CCS_CLK_HZ / 1000000);

   // =====================================================================
   // Control port request, one field per strobe
   typedef struct packed {
      logic start;
      logic [15:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
      logic stop;
   } ccs_cp_type;
endpackage

// *** design/ccs_timer.sv ***
/*
 Restartable cycle timer with a sticky done flag.
 Assumes run and clear come from the same clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module ccs_timer #(
   parameter int W = 16,
   parameter int COUNT = 1000
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic run,
   input wire logic clear,
   output logic done
);
   localparam logic [W-1:0] LAST = W'(COUNT - 1);
   logic [W-1:0] cnt;

   // =====================================================================
   // Count run cycles; done rises after COUNT of them
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt <= '0;
         done <= 1'b0;
      end else if (ce) begin
         if (clear || !run) begin
            cnt <= '0;
            done <= 1'b0;
         end else if (cnt == LAST) begin
            done <= 1'b1;
         end else begin
            cnt <= cnt + W'(1);
         end
      end
   end
endmodule
`default_nettype wire

// *** design/ccs_clock_startup.sv ***
/*
 Startup, boot gating, core clock source/enable and PLL lock control of the codec.
 Assumes rst_n is the power-on reset and the control port framing is decoded upstream.
*/
`timescale 1ns/1ns
`default_nettype none
module ccs_clock_startup
   import ccs_pkg::*;
#(
   parameter int BOOT_CYCLES = CCS_BOOT_CYCLES,
   parameter int LOCK_CYCLES = CCS_LOCK_CYCLES,
   parameter int TW = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire ccs_cp_type cpReq,
   output logic portReady,
   output logic [7:0] cpRdData,
   output logic cpRdValid,
   output logic cpDenied,
   output logic otherGrant,
   output logic coreClkOn,
   output logic [1:0] coreDivSel,
   output logic pllRun
);
   typedef enum logic [2:0] {
      ST_BOOT = 3'b001,
      ST_IDLE = 3'b010,
      ST_XFER = 3'b100
   } ccs_state_type;

   ccs_state_type state;
   logic [3:0] clkReg;
   logic [47:0] pllReg;
   logic [47:0] pllShadow;
   logic [15:0] txnAddr;
   logic [2:0] byteCnt;
   logic bootDone;
   logic lockDone;
   logic lockClear;
   logic coreRun;
   logic addrOwn;
   logic pllCommit;
   logic rdSeen;
   logic [47:0] pllView;
   logic [7:0] rdByte;

   // =====================================================================
   // Boot and lock timers
   ccs_timer #(.W(TW), .COUNT(BOOT_CYCLES)) bootTimer (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .run(1'b1),
      .clear(1'b0),
      .done(bootDone)
   );

   // Lock restarts whenever new PLL settings land; lock time is a parameter
   ccs_timer #(.W(TW), .COUNT(LOCK_CYCLES)) lockTimer (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .run(pllReg[CCS_PLL_EN_BIT]),
      .clear(lockClear),
      .done(lockDone)
   );

   // =====================================================================
   // Decode
   assign coreRun = clkReg[CCS_CLK_EN_BIT] && lockDone;
   assign addrOwn = (cpReq.addr == CCS_CLK_ADDR) || (cpReq.addr == CCS_PLL_ADDR);
   // A six-byte read must not pass for a write, or polling would restart lock
   assign pllCommit = (state == ST_XFER) && cpReq.stop && (txnAddr == CCS_PLL_ADDR)
                      && (byteCnt == CCS_PLL_BYTES) && !rdSeen;
   assign lockClear = pllCommit;
   // Stored lock bit is ignored; the live flag is spliced in on read
   always_comb begin
      pllView = pllReg;
      pllView[CCS_PLL_LOCK_BIT] = lockDone;
      rdByte = 8'h00;
      if (txnAddr == CCS_CLK_ADDR) begin
         rdByte = (byteCnt == 3'h0) ? {4'h0, clkReg} : 8'h00;
      end else if (byteCnt < CCS_PLL_BYTES) begin
         rdByte = pllView[47 - 8 * int'(byteCnt) -: 8];
      end
   end

   // =====================================================================
   // Port state: boot gate, then transaction framing
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= ST_BOOT;
         txnAddr <= 16'h0000;
         byteCnt <= 3'h0;
         cpDenied <= 1'b0;
         portReady <= 1'b0;
         otherGrant <= 1'b0;
         rdSeen <= 1'b0;
      end else if (ce) begin
         cpDenied <= 1'b0;
         unique case (state)
            ST_BOOT: begin
               cpDenied <= cpReq.start;
               if (bootDone) begin
                  state <= ST_IDLE;
                  portReady <= 1'b1;
               end
            end
            ST_IDLE: begin
               if (cpReq.start) begin
                  txnAddr <= cpReq.addr;
                  byteCnt <= 3'h0;
                  rdSeen <= 1'b0;
                  if (addrOwn || coreRun) begin
                     state <= ST_XFER;
                     otherGrant <= !addrOwn;
                  end else begin
                     cpDenied <= 1'b1;
                  end
               end
            end
            ST_XFER: begin
               if (cpReq.stop) begin
                  state <= ST_IDLE;
                  otherGrant <= 1'b0;
               end else if ((cpReq.wr || cpReq.rd) && byteCnt != 3'h7) begin
                  byteCnt <= byteCnt + 3'h1; // Saturates so overlong writes never commit
               end
               // Any read before the stop marks the transaction as not a pure write
               if (cpReq.rd && !cpReq.stop) begin
                  rdSeen <= 1'b1;
               end
            end
            default: state <= ST_BOOT;
         endcase
      end
   end

   // =====================================================================
   // Clock register, written on the first data byte only
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         clkReg <= CCS_CLK_RESET;
      end else if (ce && state == ST_XFER && cpReq.wr && !cpReq.stop
                   && txnAddr == CCS_CLK_ADDR && byteCnt == 3'h0) begin
         clkReg <= cpReq.wdata[3:0];
      end
   end

   // =====================================================================
   // PLL register: bytes gather in a shadow, land only on a complete frame
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pllShadow <= CCS_PLL_RESET;
         pllReg <= CCS_PLL_RESET;
      end else if (ce) begin
         if (state == ST_XFER && cpReq.wr && !cpReq.stop && txnAddr == CCS_PLL_ADDR) begin
            pllShadow <= {pllShadow[39:0], cpReq.wdata};
         end
         if (pllCommit) begin
            pllReg <= pllShadow & ~(48'h1 << CCS_PLL_LOCK_BIT);
         end
      end
   end

   // =====================================================================
   // Read data, one byte per read strobe, most significant first
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cpRdData <= 8'h00;
         cpRdValid <= 1'b0;
      end else if (ce) begin
         cpRdValid <= (state == ST_XFER) && cpReq.rd && !cpReq.stop && !otherGrant;
         if ((state == ST_XFER) && cpReq.rd && !otherGrant) begin
            cpRdData <= rdByte;
         end
      end
   end

   // =====================================================================
   // Core clock gate and divider; glitch-free switching is left to the clock cell
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         coreClkOn <= 1'b0;
         coreDivSel <= 2'h0;
         pllRun <= 1'b0;
      end else if (ce) begin
         coreClkOn <= clkReg[CCS_CLK_EN_BIT] && (!clkReg[CCS_SRC_BIT] || lockDone);
         coreDivSel <= clkReg[CCS_SRC_BIT] ? CCS_DIV_PLL : clkReg[2:CCS_FREQ_LSB];
         pllRun <= pllReg[CCS_PLL_EN_BIT];
      end
   end

   // =====================================================================
   // Checks
   logic [TW-1:0] lockAge;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lockAge <= '0;
      end else if (ce) begin
         // Restarts with the lock timer but counts on past its end to all ones, frozen with it while ce is low
         if (lockClear || !pllReg[CCS_PLL_EN_BIT]) begin
            lockAge <= '0;
         end else if (lockAge != '1) begin
            lockAge <= lockAge + TW'(1);
         end
      end
   end

   reset_defaults_a: assert property (@(posedge clk) !rst_n |=> clkReg == CCS_CLK_RESET && pllReg == CCS_PLL_RESET)
      else $error("registers not at defaults after reset");
   boot_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && state == ST_BOOT && !bootDone && cpReq.start |=> cpDenied && !portReady)
      else $error("access taken during boot");
   clock_off_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && !clkReg[CCS_CLK_EN_BIT] |=> !coreClkOn)
      else $error("core clock on without enable");
   pll_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && clkReg[CCS_SRC_BIT] && !lockDone |=> !coreClkOn)
      else $error("core clock on before lock");
   addr_block_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && state == ST_IDLE && cpReq.start && !addrOwn && !coreRun |=> cpDenied && state == ST_IDLE)
      else $error("prohibited address accepted");
   partial_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && state == ST_XFER && cpReq.stop && txnAddr == CCS_PLL_ADDR && byteCnt != CCS_PLL_BYTES
      |=> pllReg == $past(pllReg))
      else $error("partial PLL write committed");
   lock_time_a: assert property (@(posedge clk) disable iff (!rst_n)
      lockDone |-> lockAge >= TW'(LOCK_CYCLES))
      else $error("lock reported too early");
   direct_src_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && clkReg[CCS_CLK_EN_BIT] && !clkReg[CCS_SRC_BIT] |=> coreClkOn && coreDivSel == $past(clkReg[2:1]))
      else $error("direct clock not running");
   pll_div_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && clkReg[CCS_SRC_BIT] |=> coreDivSel == CCS_DIV_PLL)
      else $error("PLL divider not four");
   lock_ro_a: assert property (@(posedge clk) disable iff (!rst_n)
      pllCommit && ce |=> !lockDone && !pllReg[CCS_PLL_LOCK_BIT])
      else $error("lock flag taken from host write");

   boot_done_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(portReady));
   lock_seen_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(lockDone));
   pll_commit_c: cover property (@(posedge clk) disable iff (!rst_n) pllCommit && ce);
   denied_c: cover property (@(posedge clk) disable iff (!rst_n) cpDenied && portReady);
endmodule
`default_nettype wire

// *** tb/ccs_host_model.sv ***
/*
 Host controller model that drives the control port strobes.
 Assumes strobes change at falling clock edges and the device answers as the port contract says.
*/
`timescale 1ns/1ns
`default_nettype none
module ccs_host_model
   import ccs_pkg::*;
(
   input wire logic clk,
   input wire logic cpDenied,
   input wire logic cpRdValid,
   input wire logic [7:0] cpRdData,
   output ccs_cp_type cpReq
);
   // =====================================================================
   // Control port transfers
   // Each task starts on a fresh falling edge, so a strobe is never set and cleared in one step
   initial cpReq = '0;

   // Open a transaction; a refusal shows one cycle after the start
   task automatic xopen(input logic [15:0] a, output logic den);
      @(negedge clk);
      cpReq.addr = a;
      cpReq.start = 1'b1;
      @(negedge clk);
      cpReq.start = 1'b0;
      den = cpDenied;
   endtask

   // Back-to-back bytes, most significant first, one burst only
   task automatic wrs(input logic [47:0] v, input int nb);
      @(negedge clk);
      for (int i = nb - 1; i >= 0; i--) begin
         cpReq.wdata = v[8*i+:8];
         cpReq.wr = 1'b1;
         @(negedge clk);
      end
      cpReq.wr = 1'b0;
   endtask

   // Read one byte; no valid pulse gives unknown data
   task automatic rd(output logic [7:0] d);
      @(negedge clk);
      cpReq.rd = 1'b1;
      @(negedge clk);
      cpReq.rd = 1'b0;
      d = (cpRdValid === 1'b1) ? cpRdData : 8'hXX;
   endtask

   // End the transaction
   task automatic xclose;
      @(negedge clk);
      cpReq.stop = 1'b1;
      @(negedge clk);
      cpReq.stop = 1'b0;
   endtask
endmodule
`default_nettype wire

// *** tb/ccs_clock_startup_tb.sv ***
/*
 Self-checking bench for the codec clock startup control.
 Assumes short boot and lock counts and a host model owning the control port.
*/
`timescale 1ns/1ns
`default_nettype none
module ccs_clock_startup_tb
   import ccs_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   ccs_cp_type cpReq;
   logic portReady, cpRdValid, cpDenied, otherGrant, coreClkOn, pllRun, den;
   logic [7:0] cpRdData, rdv, pllTop;
   logic [1:0] coreDivSel;
   int checks = 0;
   int err_total = 0;
   int n;

   // =====================================================================
   // Clock and instances
   // 100 ns period for the 10 MHz system clock
   // It stands for a master clock at a supported ratio and a PLL reference in range
   initial begin
      forever #50 clk = ~clk;
   end
   ccs_clock_startup #(.BOOT_CYCLES(8), .LOCK_CYCLES(40)) dut_u (.clk(clk), .rst_n(rst_n), .ce(ce),
      .cpReq(cpReq), .portReady(portReady), .cpRdData(cpRdData), .cpRdValid(cpRdValid), .cpDenied(cpDenied),
      .otherGrant(otherGrant), .coreClkOn(coreClkOn), .coreDivSel(coreDivSel), .pllRun(pllRun));
   ccs_host_model host_u (.clk(clk), .cpDenied(cpDenied), .cpRdValid(cpRdValid), .cpRdData(cpRdData),
      .cpReq(cpReq));

   // =====================================================================
   // Helpers
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Reset held eight cycles; outputs must sit low meanwhile
   task automatic doReset;
      rst_n = 1'b0;
      repeat (8) @(negedge clk);
      chk({portReady, coreClkOn, pllRun, otherGrant, cpDenied, cpRdValid, coreDivSel}, 8'h00);
      chk(cpRdData, 8'h00);
      rst_n = 1'b1;
   endtask

   // Bounded wait; a hang counts as a mismatch
   task automatic giveUp(input int cnt);
      if (cnt >= 100) begin
         err_total++;
         tally_and_finish;
      end
   endtask

   task automatic putReg(input logic [15:0] a, input logic [47:0] v, input int nb);
      host_u.xopen(a, den);
      host_u.wrs(v, nb);
      host_u.xclose;
   endtask

   task automatic getClk;
      host_u.xopen(CCS_CLK_ADDR, den);
      host_u.rd(rdv);
      host_u.xclose;
   endtask

   // Whole PLL register read in six strobes; top byte and lowest byte kept
   task automatic getPllLow;
      host_u.xopen(CCS_PLL_ADDR, den);
      host_u.rd(pllTop);
      repeat (5) host_u.rd(rdv);
      host_u.xclose;
   endtask

   // =====================================================================
   // Scenarios
   initial begin
      doReset;
      host_u.xopen(CCS_CLK_ADDR, den);
      chk(den, 1);
      // Host holds off until the port is ready
      n = 0;
      while (portReady !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      giveUp(n);
      chk(n >= 6, 1);
      getClk;
      chk(rdv, {4'h0, CCS_CLK_RESET});
      chk(coreClkOn, 0);
      // Bypass with /3; upper nibble must not stick
      putReg(CCS_CLK_ADDR, 48'hF5, 1);
      @(negedge clk);
      chk({coreClkOn, coreDivSel}, 8'h06);
      getClk;
      chk(rdv, 8'h05);
      // PLL source with the core clock still off; divider forced to four
      putReg(CCS_CLK_ADDR, 48'h0A, 1);
      @(negedge clk);
      chk({coreClkOn, coreDivSel}, 8'h03);
      host_u.xopen(16'h4017, den);
      chk(den, 1);
      putReg(CCS_PLL_ADDR, 48'h123456789A03, 5);
      repeat (3) @(negedge clk);
      chk(pllRun, 0);
      putReg(CCS_PLL_ADDR, 48'h123456789A03, 6);
      repeat (3) @(negedge clk);
      chk({pllRun, coreClkOn}, 8'h02);
      // First poll falls well inside the lock time; written lock bit must not show
      getPllLow;
      chk(pllTop, 8'h12);
      chk(rdv, 8'h01);
      // Host polls the lock flag before it enables the core clock
      n = 0;
      while (rdv[CCS_PLL_LOCK_BIT] !== 1'b1 && n < 100) begin
         getPllLow;
         n++;
      end
      giveUp(n);
      chk(n >= 1, 1);
      chk(rdv, 8'h03);
      chk(coreClkOn, 0);
      putReg(CCS_CLK_ADDR, 48'h0B, 1);
      @(negedge clk);
      chk({coreClkOn, coreDivSel}, 8'h07);
      getClk;
      chk(rdv, 8'h0B);
      host_u.xopen(16'h4017, den);
      chk({den, otherGrant}, 8'h01);
      host_u.xclose;
      // Second reset in mid-run: boot gate and defaults return
      doReset;
      host_u.xopen(CCS_CLK_ADDR, den);
      chk(den, 1);
      // Clock enable low must freeze the boot count
      ce = 1'b0;
      repeat (20) @(negedge clk);
      chk(portReady, 0);
      ce = 1'b1;
      n = 0;
      while (portReady !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      giveUp(n);
      getClk;
      chk(rdv, {4'h0, CCS_CLK_RESET});
      chk({coreClkOn, pllRun}, 8'h00);
      tally_and_finish;
   end
endmodule
`default_nettype wire
